// >>> design/txreq_params.svh
// Offsets, field positions, reset values and response codes for the transmit request machine.
// Assumes a 32-bit AXI4-Lite register window with byte addresses below 0x100.
`ifndef TXREQ_PARAMS_SVH
`define TXREQ_PARAMS_SVH
`define TXR_CTRL_OFF 8'h00
`define TXR_CFG0_OFF 8'h04
`define TXR_CFG1_OFF 8'h08
`define TXR_QPTR_OFF 8'h0c
`define TXR_CNFQ_OFF 8'h10
`define TXR_ATTN_OFF 8'h14
`define TXR_CTRL_RQ 0
`define TXR_CTRL_IND 1
`define TXR_CTRL_STS 2
`define TXR_CTRL_RST 3'h7
`define TXR_CFG_ECT 0
`define TXR_CFG_PRE 1
`define TXR_CFG_SAT 2
`define TXR_CFG_FCS 3
`define TXR_CFG_PAR 4
`define TXR_CFG_RST 32'h0000_0000
`define TXR_CFG_THR_RST 8'h10
`define TXR_CFG_FCM_RST 8'hff
`define TXR_AT_RCM 0
`define TXR_AT_EXC 1
`define TXR_AT_BRK 2
`define TXR_AT_USR 3
`define TXR_RESP_OKAY 2'h0
`define TXR_RESP_SLVERR 2'h2
`endif

// >>> design/txreq_pkg.sv
// Types shared by the transmit request machine and its bench.
// Descriptor and status layouts are packed so they travel as single ports.
package txreq_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_FREQ = 6'h02, ST_FODU = 6'h04,
    ST_LOAD = 6'h08, ST_DONE = 6'h10, ST_CNF = 6'h20
  } state_t;
  typedef enum logic [1:0] {DT_MID = 2'h0, DT_FIRST = 2'h1, DT_LAST = 2'h2, DT_ONLY = 2'h3} dtype_t;
  typedef enum logic [1:0] {CC_NONE = 2'h0, CC_TX = 2'h1, CC_FULL = 2'h2, CC_RSVD = 2'h3} cclass_t;
  typedef enum logic [3:0] {
    CS_OK = 4'h0, CS_INTER = 4'h1, CS_INCONS = 4'h2, CS_NOMATCH = 4'h3,
    CS_ABORT = 4'h4, CS_ERROR = 4'h5
  } cstat_t;
  typedef struct packed {
    logic [13:0] rsvd;
    logic is_req;
    dtype_t dtype;
    logic [1:0] tclass;
    cclass_t cclass;
    logic end_cnf;
    logic inter_cnf;
    logic [7:0] fc;
    logic last_frame;
  } desc_t;
  typedef struct packed {
    logic ed_ok;
    logic [7:0] fc;
    logic own_flag;
    logic ext_match;
    logic [2:0] fstat;
    logic fcs_ok;
    logic parity_ok;
    logic stripped;
    logic void_frame;
  } rxstat_t;
  typedef struct packed {
    logic chan;
    cstat_t status;
    logic [7:0] sent;
    logic [7:0] confirmed;
  } cnf_t;
endpackage : txreq_pkg

// >>> design/fddi_transmit_request_machine.sv
// Transmit request machine: descriptor fetch, request FIFO, token request,
// byte stream to the ring engine and confirmation descriptors.
// Assumes host memory and the ring engine are logic on aclk; registers over AXI4-Lite.
`timescale 1ns/1ps
`include "txreq_params.svh"
module fddi_transmit_request_machine #(
  parameter int FIFO_DEPTH = 64
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic fetch_req,
  output logic fetch_is_req,
  output logic fetch_chan,
  output logic fetch_repeat,
  input wire logic fetch_ack,
  input wire logic fetch_err,
  input wire txreq_pkg::desc_t fetch_desc,
  input wire logic data_valid,
  input wire logic [7:0] data_byte,
  input wire logic data_last,
  output logic data_ready,
  output logic tok_req,
  output logic [1:0] tok_class,
  input wire logic tok_granted,
  input wire logic service_end,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic tx_last,
  input wire logic tx_ready,
  input wire logic rx_end,
  input wire txreq_pkg::rxstat_t rx_stat,
  input wire logic token_seen,
  input wire logic mac_reset_event,
  input wire logic ring_op,
  input wire logic [2:0] machine_error,
  output logic indicate_halt,
  output logic status_halt,
  output logic cnf_valid,
  output txreq_pkg::cnf_t cnf_desc,
  input wire logic cnf_ready
);
  localparam int AW = $clog2(FIFO_DEPTH);

  txreq_pkg::state_t st_q;
  txreq_pkg::desc_t ctx_q [2];
  logic [2:0] halt_q;
  logic [31:0] cfg_q [2];
  logic [7:0] rqp_q [2];
  logic [7:0] rql_q [2];
  logic [7:0] cnp_q, cnl_q;
  logic [3:0] attn_q;
  logic [3:0] attn_set;
  logic cur_q, skip_q, started_q, end_in_q, tx_run_q, ring_op_q, cnf_done_q;
  logic [1:0] resume_q, so_done_q, elig;
  logic [8:0] mem_q [FIFO_DEPTH];
  logic [AW-1:0] wptr_q, rptr_q, fstart_q;
  logic [AW:0] fcnt_q, fbytes_q;
  logic [7:0] sent_q, conf_q;
  logic cnt_on_q, cnt_end_q, cnt_bad_q;
  logic aw_got_q, w_got_q;
  logic [7:0] awa_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic run, all_halt, push, pop, committed, start, preempt, flush, rx_match, rx_own;
  logic wr_en, cfg_ok, cur_ect, cur_done, abort_cnt, ring_chg;
  txreq_pkg::desc_t cur;

  // Merges a write with byte strobes into an old register value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Basic decode of the running channel and its configuration.
  assign run = !halt_q[`TXR_CTRL_RQ];
  assign all_halt = &halt_q;
  assign cur = ctx_q[cur_q];
  assign cur_ect = cfg_q[cur_q][`TXR_CFG_ECT];
  assign indicate_halt = halt_q[`TXR_CTRL_IND];
  assign status_halt = halt_q[`TXR_CTRL_STS];
  assign ring_chg = ring_op ^ ring_op_q;

  // Channel eligibility; a resumed channel needs no new request descriptor.
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      elig[c] = run && !attn_q[`TXR_AT_USR] && !so_done_q[c]
        && (resume_q[c] || (!(rqp_q[c] > rql_q[c]) && cnp_q != cnl_q));
    end
  end

  // FIFO traffic. The purge only removes the current, never-started frame.
  assign push = data_valid && data_ready;
  assign pop = tx_valid && tx_ready;
  assign committed = end_in_q || (8'(fbytes_q) >= cfg_q[cur_q][15:8]);
  assign start = st_q == txreq_pkg::ST_LOAD && run && committed && tok_granted
    && !tx_run_q && !started_q;
  assign preempt = cur_q && cfg_q[0][`TXR_CFG_PRE] && elig[0] && !started_q
    && (st_q == txreq_pkg::ST_FODU || st_q == txreq_pkg::ST_LOAD);
  assign flush = preempt && st_q == txreq_pkg::ST_LOAD;
  assign data_ready = st_q == txreq_pkg::ST_LOAD && run && !end_in_q && !preempt
    && fcnt_q < (AW+1)'(FIFO_DEPTH)
    && (!cur_q || cfg_q[1][`TXR_CFG_PRE] || tok_granted);
  assign tx_valid = tx_run_q && fcnt_q != '0;
  assign tx_byte = mem_q[rptr_q][7:0];
  assign tx_last = mem_q[rptr_q][8];
  assign cur_done = cur.dtype == txreq_pkg::DT_LAST || cur.dtype == txreq_pkg::DT_ONLY;

  // Fetch port requests descriptors for the channel being served.
  assign fetch_req = run && (st_q == txreq_pkg::ST_FREQ || (st_q == txreq_pkg::ST_FODU && !preempt));
  assign fetch_is_req = st_q == txreq_pkg::ST_FREQ;
  assign fetch_chan = cur_q;

  // Request FIFO storage and pointers.
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[wptr_q] <= {data_last, data_byte};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr_q <= '0;
      rptr_q <= '0;
      fcnt_q <= '0;
    end else begin
      wptr_q <= flush ? fstart_q : wptr_q + AW'(push);
      rptr_q <= rptr_q + AW'(pop);
      fcnt_q <= fcnt_q + (AW+1)'(push) - (AW+1)'(pop) - (flush ? fbytes_q : '0);
    end
  end

  // Transmission of committed frames; the stream runs until the frame's last byte.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_run_q <= 1'b0;
      sent_q <= 8'h00;
    end else begin
      if (start) begin
        tx_run_q <= 1'b1;
        sent_q <= sent_q + 8'h01;
      end else if (pop && tx_last) begin
        tx_run_q <= 1'b0;
      end
      if (st_q == txreq_pkg::ST_FREQ) begin
        sent_q <= 8'h00;
      end
    end
  end

  // Full confirmation matching of returning frames.
  assign rx_own = rx_stat.own_flag || (cfg_q[cur_q][`TXR_CFG_SAT] && rx_stat.ext_match);
  assign rx_match = rx_stat.ed_ok && rx_own
    && ((rx_stat.fc ^ cur.fc) & cfg_q[cur_q][23:16]) == 8'h00
    && rx_stat.fstat == cfg_q[cur_q][26:24]
    && (rx_stat.fcs_ok || !cfg_q[cur_q][`TXR_CFG_FCS])
    && (rx_stat.parity_ok || !cfg_q[cur_q][`TXR_CFG_PAR]);
  assign abort_cnt = mac_reset_event || ring_chg || token_seen
    || (rx_end && !rx_stat.void_frame && (rx_stat.stripped
    || (cfg_q[cur_q][`TXR_CFG_PAR] && !rx_stat.parity_ok)));

  // Confirmed frame counter. Only the request in service is tracked.
  always_ff @(posedge aclk) begin
    if (!aresetn || st_q == txreq_pkg::ST_FREQ) begin
      cnt_on_q <= 1'b0;
      cnt_end_q <= 1'b0;
      cnt_bad_q <= 1'b0;
      conf_q <= 8'h00;
    end else if (cur.cclass == txreq_pkg::CC_FULL && !cnt_end_q && sent_q != 8'h00) begin
      if (abort_cnt && (cnt_on_q || !rx_end)) begin
        cnt_end_q <= 1'b1;
        cnt_bad_q <= 1'b1;
      end else if (rx_end && !rx_stat.void_frame && (cnt_on_q || rx_own)) begin
        cnt_on_q <= 1'b1;
        if (rx_match) begin
          conf_q <= conf_q + 8'h01;
        end else begin
          cnt_end_q <= 1'b1;
          cnt_bad_q <= 1'b1;
        end
      end else if (st_q == txreq_pkg::ST_DONE && !tx_run_q && conf_q == sent_q) begin
        cnt_end_q <= 1'b1;
      end
    end
  end

  // Request sequencing: fetch, check, load, transmit, confirm.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= txreq_pkg::ST_IDLE;
      cur_q <= 1'b0;
      skip_q <= 1'b0;
      started_q <= 1'b0;
      end_in_q <= 1'b0;
      fbytes_q <= '0;
      fstart_q <= '0;
      resume_q <= 2'b00;
      fetch_repeat <= 1'b0;
      tok_req <= 1'b0;
      tok_class <= 2'h0;
      ctx_q[0] <= '0;
      ctx_q[1] <= '0;
    end else begin
      if (push) begin
        fbytes_q <= fbytes_q + (AW+1)'(1);
        end_in_q <= data_last;
      end
      // A frame shorter than the threshold commits by its end, so the request must not wait for a push.
      if (st_q == txreq_pkg::ST_LOAD && !cur_ect && committed) begin
        tok_req <= 1'b1;
      end
      if (start) begin
        started_q <= 1'b1;
        tok_req <= 1'b1;
      end
      case (st_q)
        txreq_pkg::ST_IDLE: begin
          if (elig[0] || elig[1]) begin
            cur_q <= !elig[0];
            fetch_repeat <= resume_q[!elig[0]];
            st_q <= resume_q[!elig[0]] ? txreq_pkg::ST_FODU : txreq_pkg::ST_FREQ;
          end
        end
        txreq_pkg::ST_FREQ: begin
          if (fetch_ack && run) begin
            ctx_q[cur_q] <= fetch_desc;
            if (fetch_err) begin
              st_q <= txreq_pkg::ST_CNF;
            end else if (skip_q) begin
              skip_q <= !(fetch_desc.dtype == txreq_pkg::DT_LAST || fetch_desc.dtype == txreq_pkg::DT_ONLY);
              st_q <= txreq_pkg::ST_IDLE;
            end else if (!fetch_desc.is_req || !ring_op || fetch_desc.cclass == txreq_pkg::CC_RSVD
                || fetch_desc.dtype == txreq_pkg::DT_MID || fetch_desc.dtype == txreq_pkg::DT_LAST) begin
              st_q <= txreq_pkg::ST_CNF;
            end else begin
              tok_req <= cfg_q[cur_q][`TXR_CFG_ECT] && fetch_desc.dtype == txreq_pkg::DT_FIRST;
              tok_class <= fetch_desc.tclass;
              st_q <= txreq_pkg::ST_FODU;
            end
          end
        end
        txreq_pkg::ST_FODU: begin
          if (preempt) begin
            resume_q[1] <= 1'b1;
            st_q <= txreq_pkg::ST_IDLE;
          end else if (fetch_ack && run) begin
            fetch_repeat <= 1'b0;
            resume_q[cur_q] <= 1'b0;
            ctx_q[cur_q].last_frame <= fetch_desc.last_frame;
            started_q <= 1'b0;
            end_in_q <= 1'b0;
            fbytes_q <= '0;
            fstart_q <= wptr_q;
            st_q <= (fetch_err || fetch_desc.is_req) ? txreq_pkg::ST_CNF : txreq_pkg::ST_LOAD;
          end
        end
        txreq_pkg::ST_LOAD: begin
          if (flush) begin
            resume_q[1] <= 1'b1;
            fetch_repeat <= 1'b1;
            tok_req <= 1'b0;
            st_q <= txreq_pkg::ST_IDLE;
          end else if (started_q && end_in_q) begin
            st_q <= cur.last_frame ? txreq_pkg::ST_DONE : txreq_pkg::ST_FODU;
          end
        end
        txreq_pkg::ST_DONE: begin
          if (!tx_run_q && (cur.cclass != txreq_pkg::CC_FULL || cnt_end_q)) begin
            tok_req <= 1'b0;
            st_q <= txreq_pkg::ST_CNF;
          end
        end
        txreq_pkg::ST_CNF: begin
          if (cnf_done_q) begin
            skip_q <= attn_set[`TXR_AT_EXC] && !cur_done;
            st_q <= txreq_pkg::ST_IDLE;
          end
        end
        default: st_q <= txreq_pkg::ST_IDLE;
      endcase
    end
  end

  // Outcome of the request, valid while the sequencer sits in the confirm state.
  txreq_pkg::cstat_t outcome;
  always_comb begin
    outcome = txreq_pkg::CS_OK;
    attn_set = 4'h0;
    if (st_q == txreq_pkg::ST_CNF) begin
      attn_set[`TXR_AT_RCM] = 1'b1;
      if (fetch_err || halt_q[`TXR_CTRL_RQ]) begin
        outcome = txreq_pkg::CS_ERROR;
      end else if (sent_q == 8'h00) begin
        outcome = txreq_pkg::CS_INCONS;
      end else if (cnt_bad_q && rx_end) begin
        outcome = txreq_pkg::CS_NOMATCH;
        attn_set[`TXR_AT_BRK] = 1'b1;
      end else if (cnt_bad_q) begin
        outcome = txreq_pkg::CS_ABORT;
      end
      if (outcome != txreq_pkg::CS_OK) begin
        attn_set[`TXR_AT_EXC] = 1'b1;
        attn_set[`TXR_AT_USR] = 1'b1;
      end
    end
  end

  // Confirmation descriptor output and the per-channel service opportunity flags.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnf_valid <= 1'b0;
      cnf_desc <= '0;
      cnf_done_q <= 1'b0;
      so_done_q <= 2'b00;
    end else begin
      cnf_done_q <= 1'b0;
      if (service_end) begin
        so_done_q <= 2'b00;
      end
      if (cnf_valid && cnf_ready) begin
        cnf_valid <= 1'b0;
        cnf_done_q <= st_q == txreq_pkg::ST_CNF;
      end else if (st_q == txreq_pkg::ST_CNF && !cnf_valid && !cnf_done_q) begin
        so_done_q[cur_q] <= 1'b1;
        if (outcome != txreq_pkg::CS_OK || cur.end_cnf || cur.inter_cnf) begin
          cnf_valid <= 1'b1;
          cnf_desc <= '{chan: cur_q, status: outcome, sent: sent_q, confirmed: conf_q};
        end else begin
          cnf_done_q <= 1'b1;
        end
      end else if (service_end && !cnf_valid && cur.inter_cnf
          && st_q != txreq_pkg::ST_IDLE && st_q != txreq_pkg::ST_CNF) begin
        cnf_valid <= 1'b1;
        cnf_desc <= '{chan: cur_q, status: txreq_pkg::CS_INTER, sent: sent_q, confirmed: conf_q};
      end
    end
  end

  // AXI4-Lite write and read channels; address and data are taken in either order.
  assign awready = !aw_got_q && !bvalid;
  assign wready = !w_got_q && !bvalid;
  assign wr_en = aw_got_q && w_got_q;
  assign cfg_ok = all_halt;
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `TXR_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got_q <= 1'b1;
        awa_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_q <= 1'b1;
        wd_q <= wdata;
        ws_q <= wstrb;
      end
      if (wr_en) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (awa_q > `TXR_ATTN_OFF || awa_q[1:0] != 2'b00) ? `TXR_RESP_SLVERR : `TXR_RESP_OKAY;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Register state owned by software, with hardware updates folded in.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halt_q <= `TXR_CTRL_RST;
      attn_q <= 4'h0;
      ring_op_q <= 1'b0;
      cnp_q <= 8'h00;
      cnl_q <= 8'h00;
      for (int c = 0; c < 2; c++) begin
        cfg_q[c] <= {5'h0, 3'h0, `TXR_CFG_FCM_RST, `TXR_CFG_THR_RST, 8'h00} | `TXR_CFG_RST;
        rqp_q[c] <= 8'h00;
        rql_q[c] <= 8'h00;
      end
    end else begin
      ring_op_q <= ring_op;
      if (wr_en && awa_q == `TXR_CTRL_OFF && ws_q[0]) begin
        halt_q <= wd_q[2:0];
      end
      if (wr_en && cfg_ok && awa_q == `TXR_CFG0_OFF) begin
        cfg_q[0] <= merge(cfg_q[0], wd_q, ws_q);
      end
      if (wr_en && cfg_ok && awa_q == `TXR_CFG1_OFF) begin
        cfg_q[1] <= merge(cfg_q[1], wd_q, ws_q);
      end
      if (wr_en && awa_q == `TXR_QPTR_OFF) begin
        {rql_q[1], rqp_q[1], rql_q[0], rqp_q[0]} <= merge({rql_q[1], rqp_q[1], rql_q[0], rqp_q[0]}, wd_q, ws_q);
      end
      if (st_q == txreq_pkg::ST_FREQ && fetch_ack && run) begin
        rqp_q[cur_q] <= rqp_q[cur_q] + 8'h01;
      end
      if (wr_en && awa_q == `TXR_CNFQ_OFF) begin
        {cnl_q, cnp_q} <= 16'(merge({16'h0, cnl_q, cnp_q}, wd_q, ws_q));
      end
      if (cnf_valid && cnf_ready) begin
        cnp_q <= cnp_q + 8'h01;
      end
      // Write one to clear; a new event in the same cycle wins.
      attn_q <= (attn_q & ~((wr_en && awa_q == `TXR_ATTN_OFF) ? wd_q[3:0] : 4'h0))
        | ((st_q == txreq_pkg::ST_CNF && !cnf_valid && !cnf_done_q) ? attn_set : 4'h0);
      // A fetch error stops the request machine, the other error inputs stop their own machine.
      halt_q <= (wr_en && awa_q == `TXR_CTRL_OFF && ws_q[0] ? wd_q[2:0] : halt_q)
        | machine_error | {2'b00, fetch_ack && fetch_err};
    end
  end

  // Read data for all mapped registers; unmapped reads answer a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `TXR_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= `TXR_RESP_OKAY;
      case (araddr)
        `TXR_CTRL_OFF: rdata <= {23'h0, st_q, halt_q};
        `TXR_CFG0_OFF: rdata <= cfg_q[0];
        `TXR_CFG1_OFF: rdata <= cfg_q[1];
        `TXR_QPTR_OFF: rdata <= {rql_q[1], rqp_q[1], rql_q[0], rqp_q[0]};
        `TXR_CNFQ_OFF: rdata <= {16'h0, cnl_q, cnp_q};
        `TXR_ATTN_OFF: rdata <= {28'h0, attn_q};
        default: begin
          rdata <= 32'h0;
          rresp <= `TXR_RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : fddi_transmit_request_machine

// >>> verif/txreq_props.sv
// Checker for the handshakes and halt bits of the transmit request machine.
// Assumes it is bound to the design top and sees only its ports.
`timescale 1ns/1ps
module txreq_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic fetch_req,
  input wire logic fetch_ack,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_byte,
  input wire logic tok_granted,
  input wire logic cnf_valid,
  input wire logic cnf_ready,
  input wire txreq_pkg::cnf_t cnf_desc,
  input wire logic [2:0] machine_error,
  input wire logic indicate_halt,
  input wire logic status_halt
);
  // Everything runs on aclk and rests while reset is low.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence tx_stall;
    tx_valid && !tx_ready;
  endsequence
  // The write lands one cycle after both halves are taken, and its answer stands the cycle after.
  AST_WR_RESP: assert property (wr_taken |-> ##2 bvalid) else $error("write answer missing");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped");
  AST_FETCH_HOLD: assert property (fetch_req && !fetch_ack |=> fetch_req) else $error("fetch dropped");
  // A frame may only begin once the token was held at the starting edge.
  AST_TX_START: assert property ($rose(tx_valid) |-> $past(tok_granted)) else $error("tx without token");
  AST_TX_HOLD: assert property (tx_stall |=> tx_valid && $stable(tx_byte)) else $error("tx byte moved");
  AST_CNF_HOLD: assert property (cnf_valid && !cnf_ready |=> cnf_valid && $stable(cnf_desc)) else $error("cnf moved");
  AST_IND_HALT: assert property (machine_error[1] |=> indicate_halt) else $error("indicate not halted");
  AST_STS_HALT: assert property (machine_error[2] |=> status_halt) else $error("status not halted");
endmodule : txreq_props
bind fddi_transmit_request_machine txreq_props chk (.*);

// >>> verif/txreq_partner.sv
// Host memory and ring engine model facing the transmit request machine.
// Assumes one aclk domain; answers fetches, feeds frame bytes and grants tokens.
`timescale 1ns/1ps
module ring_host_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fetch_req,
  input wire logic fetch_is_req,
  output logic fetch_ack,
  output txreq_pkg::desc_t fetch_desc,
  output logic data_valid,
  output logic [7:0] data_byte,
  output logic data_last,
  input wire logic data_ready,
  input wire logic tok_req,
  output logic tok_granted,
  output logic service_end,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_last
);
  logic [7:0] len;
  logic [7:0] k;
  logic [2:0] wt;
  // Answers alternate prompt and slow; an idle descriptor bus shows a changing pattern.
  always_ff @(posedge aclk) begin
    wt <= wt + 3'h1;
    fetch_ack <= 1'b0;
    fetch_desc <= ~fetch_desc;
    if (!aresetn) begin
      wt <= 3'h0;
      fetch_desc <= '0;
    end else if (fetch_req && !fetch_ack && !data_valid && (k[0] || wt[1:0] == 2'h0)) begin
      fetch_ack <= 1'b1;
      fetch_desc <= '{rsvd: '0, is_req: fetch_is_req, dtype: txreq_pkg::DT_ONLY, tclass: 2'h2,
        cclass: txreq_pkg::CC_TX, end_cnf: 1'b1, inter_cnf: 1'b0, fc: 8'h50, last_frame: 1'b1};
    end
  end
  // Frame lengths 3, 10 and 17 straddle the commit threshold of 4.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_valid <= 1'b0;
      k <= 8'h0;
      len <= 8'h0;
      data_byte <= 8'h0;
      data_last <= 1'b0;
    end else if (fetch_ack && !fetch_desc.is_req) begin
      data_valid <= 1'b1;
      data_last <= 1'b0;
      len <= 8'h3 + 8'(k * 7);
      k <= k + 8'h1;
    end else if (data_valid && data_ready) begin
      len <= len - 8'h1;
      data_byte <= data_byte + 8'h3b;
      data_last <= len == 8'h2;
      data_valid <= !data_last;
    end else if (!data_valid) begin
      data_byte <= ~data_byte;
      data_last <= ~data_last;
    end
  end
  // The token comes some cycles after the request and is given up at frame end.
  // An unused token passing by also ends a service opportunity, so a served channel may ask again.
  always_ff @(posedge aclk) begin
    service_end <= 1'b0;
    if (!aresetn) begin
      tok_granted <= 1'b0;
    end else if (tx_valid && tx_ready && tx_last) begin
      tok_granted <= 1'b0;
      service_end <= 1'b1;
    end else begin
      tok_granted <= tok_req && (tok_granted || wt == 3'h7);
      service_end <= !tok_req && !tok_granted && wt == 3'h7;
    end
  end
endmodule : ring_host_model

// >>> verif/tb_top.sv
// Self-checking bench for the transmit request machine.
// Assumes the host and ring model in txreq_partner.sv and the bound checker.
`timescale 1ns/1ps
`include "txreq_params.svh"
module tb_top;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic fetch_req, fetch_is_req, fetch_chan, fetch_repeat, fetch_ack, fetch_err, data_valid, data_last, data_ready;
  logic tok_req, tok_granted, service_end, tx_valid, tx_last, tx_ready, rx_end, token_seen, mac_reset_event;
  logic ring_op, indicate_halt, status_halt, cnf_valid, cnf_ready;
  logic [7:0] awaddr, araddr, data_byte, tx_byte;
  logic [31:0] wdata, rdata, rv;
  logic [1:0] bresp, rresp, tok_class, rsp;
  logic [3:0] wstrb;
  logic [2:0] machine_error;
  txreq_pkg::desc_t fetch_desc;
  txreq_pkg::rxstat_t rx_stat;
  txreq_pkg::cnf_t cnf_desc;
  logic [8:0] q[$];
  int mismatches, checks, ncnf;
  integer seed = 32'hd380;
  fddi_transmit_request_machine DUT (.*);
  ring_host_model partner (.*);
  // The 25 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task end_of_test;
    if (mismatches == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  // One AXI4-Lite access; ready is sampled before the edge that moves each item.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, tr, tk;
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    for (n = 0; n < 99; n++) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tr = arvalid & arready;
      tk = w ? bvalid : rvalid;
      rv = rdata;
      rsp = w ? bresp : rresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr) arvalid <= 1'b0;
      if (tk) break;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    @(posedge aclk);
    if (n == 99) begin
      mismatches++;
      end_of_test();
    end
  endtask : bus
  // Random stalls from the ring and the confirmation writer.
  always @(posedge aclk) begin
    tx_ready <= 1'($random(seed));
    cnf_ready <= 1'($random(seed));
  end
  // Reference model: host bytes queue up and must leave on the ring in order.
  always @(posedge aclk) begin
    if (aresetn && data_valid && data_ready) q.push_back({data_last, data_byte});
    if (aresetn && tx_valid && tx_ready) chk("tx byte", {tx_last, tx_byte}, q.pop_front());
    if (aresetn && fetch_ack) chk("fetch chan", fetch_chan, 1'b0);
    if (aresetn && cnf_valid && cnf_ready) begin
      ncnf++;
      chk("cnf", cnf_desc, {1'b0, txreq_pkg::CS_OK, 8'h01, 8'h00});
      chk("token class", tok_class, 2'h2);
    end
  end
  initial begin
    int n;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {rx_end, token_seen, mac_reset_event, fetch_err, machine_error, rx_stat} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    ring_op = 1'b1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    bus(1'b0, `TXR_CTRL_OFF, 32'h0);
    chk("halt bits", rv[2:0], 3'h7);
    bus(1'b0, 8'h18, 32'h0);
    chk("unmapped", rsp, `TXR_RESP_SLVERR);
    bus(1'b1, `TXR_CFG0_OFF, 32'h0000_0400);
    bus(1'b1, `TXR_QPTR_OFF, 32'h0203_0200);
    bus(1'b1, `TXR_CNFQ_OFF, 32'h0000_0800);
    bus(1'b1, `TXR_CTRL_OFF, 32'h0);
    bus(1'b1, `TXR_CFG0_OFF, 32'h0000_0800);
    chk("refused cfg answer", rsp, `TXR_RESP_OKAY);
    bus(1'b0, `TXR_CFG0_OFF, 32'h0);
    chk("cfg while running", rv, 32'h0000_0400);
    for (n = 0; n < 4000 && ncnf < 3; n++) @(posedge aclk);
    repeat (60) @(posedge aclk);
    chk("confirmations", ncnf, 3);
    chk("bytes left", q.size(), 0);
    bus(1'b0, `TXR_QPTR_OFF, 32'h0);
    chk("request pointer", rv, 32'h0203_0203);
    bus(1'b0, `TXR_CNFQ_OFF, 32'h0);
    chk("cnf pointer", rv, 32'h0000_0803);
    bus(1'b0, `TXR_ATTN_OFF, 32'h0);
    chk("attention", rv[3:0], 4'h1);
    machine_error <= 3'h6;
    {token_seen, mac_reset_event} <= 2'h3;
    @(posedge aclk);
    machine_error <= 3'h0;
    {token_seen, mac_reset_event} <= 2'h0;
    @(posedge aclk);
    @(negedge aclk);
    chk("halts", {indicate_halt, status_halt}, 2'h3);
    end_of_test();
  end
endmodule : tb_top
